// File: core/ibf_defs.svh
// constants for the i2c framing block: mode codes, status positions, timing
`ifndef IBF_DEFS_SVH
`define IBF_DEFS_SVH
`define IBF_MODE_I2C      2'h3
`define IBF_HDR10_PAT     5'h1e
`define IBF_STAT_BUSY     4
`define IBF_STAT_W        16
`define IBF_STAT_RST_MASK 16'h008f
`define IBF_FLAG_W        8
`define IBF_FLAG_RST      8'h02
`define IBF_FLAG_START    2
`define IBF_FLAG_STOP     3
`define IBF_FLAG_RX       0
`define IBF_FLAG_TX       1
`define IBF_CLK_MHZ       40
`define IBF_SM_KBPS       100
`define IBF_FM_KBPS       400
`define IBF_HALF_SM       ((`IBF_CLK_MHZ * 1000) / (2 * `IBF_SM_KBPS))
`define IBF_HALF_FM       ((`IBF_CLK_MHZ * 1000) / (2 * `IBF_FM_KBPS))
`define IBF_NADDR         4
`endif

// File: core/ibf_fifo.sv
// small valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module ibf_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         flush,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  cnt_r;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] wp_r;
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;
   assign in_ready  = (cnt_r != D[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         rp_r  <= '0;
         wp_r  <= '0;
      end else if (flush) begin
         cnt_r <= '0;
         rp_r  <= '0;
         wp_r  <= '0;
      end else begin
         if (push) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
         if (pop) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem[wp_r] <= in_data;
   end
endmodule
`default_nettype wire

// File: core/ibf_i2c.sv
// i2c framing core: reset hold, start/stop detection, byte framing, addressing
//
// Contract
// - power-up clear sets the soft reset hold bit
// - clearing soft reset hold releases the block
// - while held, bus traffic stops and both drivers are released
// - holding clears status bits 15-8 and 6-4
// - holding clears interrupt enable and flag words and flushes both tx and rx fifos
// - master makes one scl pulse per data bit
// - bytes are eight bits, msb first
// - first byte after start is 7-bit address plus direction bit
// - receiver drives acknowledge on the ninth clock
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - only the bus master makes start and stop
// - busy flag set on start, cleared on stop
// - sda changes only while scl is low
// - 10-bit header is 11110, two address msbs, direction
// - 10-bit header followed by low eight address bits, ack, data
// - repeated start resends address with new direction
// - standard 100 kbps and fast 400 kbps, programmable master bit rate
// - up to four own slave addresses, each with its own event
// - 8-bit byte counter raises an event only when it auto stops
// - slave when mode 11, sync set, master select clear
// - matching address after start sets start match flag
`timescale 1ns/100ps
`default_nettype none
`include "ibf_defs.svh"
module ibf_i2c
   import ibf_pkg::*;
#(
   parameter int NADDR = `IBF_NADDR
) (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  soft_reset_set,
   input  wire logic                  soft_reset_clr,
   input  wire logic [1:0]            mode_select_field,
   input  wire logic                  sync_mode_bit,
   input  wire logic                  master_select_bit,
   input  wire logic                  fast_mode,
   input  wire logic [15:0]           bit_rate_div,
   input  wire logic [9:0]            own_addr [NADDR],
   input  wire logic [NADDR-1:0]      own_addr_en,
   input  wire logic                  own_addr_ten,
   input  wire logic [7:0]            byte_count_limit,
   input  wire logic                  auto_stop_en,
   input  wire ibf_cmd_s              cmd,
   input  wire logic                  cmd_valid,
   input  wire logic [7:0]            tx_data,
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   output logic [8:0]                 rx_data,
   output logic                       rx_valid,
   input  wire logic                  rx_ready,
   input  wire logic [7:0]            int_enable_wr,
   input  wire logic                  int_enable_we,
   input  wire logic [`IBF_FLAG_W-1:0] int_flag_clr,
   output logic                       soft_reset_hold,
   output logic [15:0]                status_word_reg,
   output logic [7:0]                 int_enable_reg,
   output logic [`IBF_FLAG_W-1:0]     int_flag_reg,
   output logic [NADDR-1:0]           addr_match_evt,
   output logic                       bus_busy_flag,
   output logic                       start_match_flag,
   output logic                       sda_o,
   output logic                       sda_oe,
   output logic                       scl_o,
   output logic                       scl_oe,
   input  wire logic                  sda_i,
   input  wire logic                  scl_i
);
   typedef struct packed {
      logic [2:0]  sda_sy;
      logic [2:0]  scl_sy;
      logic        sda_q;
      logic        scl_q;
      logic        hold;
      logic [15:0] stat;
      logic [7:0]  ien;
      logic [7:0]  ifg;
      ibf_state_e  st;
      logic [15:0] div;
      logic [3:0]  bitn;
      logic [8:0]  sh;
      logic        hdr2;
      logic        hdr_sent;
      logic        adr_phase;
      logic        ack_me;
      logic        sread;
      logic        stop_pend;
      logic [7:0]  bcnt;
      logic        sda_oe;
      logic        scl_oe;
      logic [8:0]  rxd;
      logic        rxv;
      logic [NADDR-1:0] amatch;
      ibf_cmd_s    c;
   } ibf_st_s;
   ibf_st_s s_r;
   ibf_st_s s_nxt;
   ibf_byte_s rxf_in;
   logic      txf_valid;
   logic      rxf_ready;
   logic [7:0] txf_data;
   logic      txf_pop;
   logic      rxf_push;
   ////////////////////////////////////////////////////////////////////////////////
   ibf_fifo #(.W(8), .D(4)) u_txf (
      .clk(clk), .resetn(resetn), .flush(s_r.hold),
      .in_data(tx_data), .in_valid(tx_valid), .in_ready(tx_ready),
      .out_data(txf_data), .out_valid(txf_valid), .out_ready(txf_pop));
   ibf_fifo #(.W(9), .D(4)) u_rxf (
      .clk(clk), .resetn(resetn), .flush(s_r.hold),
      .in_data(rxf_in), .in_valid(rxf_push), .in_ready(rxf_ready),
      .out_data(rx_data), .out_valid(rx_valid), .out_ready(rx_ready));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] hdr_byte(input ibf_cmd_s c, input logic second);
      if (second) return c.addr[7:0];
      if (c.ten_bit) return {`IBF_HDR10_PAT, c.addr[9:8], c.read};
      return {c.addr[6:0], c.read};
   endfunction
   wire sda_s = s_r.sda_sy[2];
   wire scl_s = s_r.scl_sy[2];
   wire sda_ok = (s_r.sda_sy[2] == s_r.sda_sy[1]);
   wire scl_ok = (s_r.scl_sy[2] == s_r.scl_sy[1]);
   wire start_det = sda_ok && scl_ok && s_r.sda_q && !sda_s && scl_s && s_r.scl_q;
   wire stop_det  = sda_ok && scl_ok && !s_r.sda_q && sda_s && scl_s && s_r.scl_q;
   wire scl_rise  = scl_ok && !s_r.scl_q && scl_s;
   wire scl_fall  = scl_ok && s_r.scl_q && !scl_s;
   wire is_i2c    = (mode_select_field == `IBF_MODE_I2C) && sync_mode_bit;
   wire [15:0] half = (bit_rate_div != 16'h0) ? bit_rate_div :
                      (fast_mode ? 16'(`IBF_HALF_FM) : 16'(`IBF_HALF_SM));
   assign txf_pop  = (s_r.st == ST_M_BIT_LO) && (s_r.bitn == 4'h0) && s_r.div == 16'h0
                     && !s_r.adr_phase && !s_r.c.read && txf_valid;
   assign rxf_push = s_r.rxv;
   assign rxf_in   = s_r.rxd;
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [7:0] b;
      logic       m;
      b = 8'h0;
      m = 1'b0;
      s_nxt = s_r;
      s_nxt.rxv = 1'b0;
      s_nxt.amatch = '0;
      s_nxt.sda_sy = {s_r.sda_sy[1:0], sda_i};
      s_nxt.scl_sy = {s_r.scl_sy[1:0], scl_i};
      if (sda_ok) s_nxt.sda_q = sda_s;
      if (scl_ok) s_nxt.scl_q = scl_s;
      if (soft_reset_set) s_nxt.hold = 1'b1;
      else if (soft_reset_clr) s_nxt.hold = 1'b0;
      if (int_enable_we) s_nxt.ien = int_enable_wr;
      s_nxt.ifg = s_r.ifg & ~int_flag_clr;
      if (start_det) s_nxt.stat[`IBF_STAT_BUSY] = 1'b1;
      if (stop_det) s_nxt.stat[`IBF_STAT_BUSY] = 1'b0;
      s_nxt.stat[15:8] = s_r.bcnt;
      if (s_r.div != 16'h0) s_nxt.div = s_r.div - 16'h1;
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.scl_oe = 1'b0;
            if (is_i2c && master_select_bit && cmd_valid && cmd.start &&
                (!s_r.stat[`IBF_STAT_BUSY] || s_r.hdr_sent)) begin
               s_nxt.c = cmd;
               s_nxt.sda_oe = 1'b1;
               s_nxt.div = half;
               s_nxt.st = ST_M_START;
            end else if (is_i2c && !master_select_bit && start_det) begin
               s_nxt.bitn = 4'h0;
               s_nxt.adr_phase = 1'b1;
               s_nxt.hdr2 = 1'b0;
               s_nxt.st = ST_S_BIT;
            end
         end
         ST_M_START: if (s_r.div == 16'h0) begin
            s_nxt.scl_oe = 1'b1;
            s_nxt.bitn = 4'h0;
            s_nxt.adr_phase = 1'b1;
            s_nxt.hdr2 = 1'b0;
            s_nxt.bcnt = 8'h0;
            s_nxt.sh = {hdr_byte(s_r.c, 1'b0), 1'b1};
            s_nxt.div = half;
            s_nxt.st = ST_M_BIT_LO;
         end
         ST_M_BIT_LO: begin
            if (s_r.bitn == 4'h0 && !s_r.adr_phase && !s_r.c.read) begin
               if (!txf_valid) s_nxt.div = half;
               else if (s_r.div == 16'h0) s_nxt.sh = {txf_data, 1'b1};
            end
            // sda only moves in the scl low phase
            if (s_r.c.read && !s_r.adr_phase)
               s_nxt.sda_oe = (s_r.bitn == 4'h8) &&
                              (s_r.bcnt + 8'h1 != byte_count_limit);
            else if (s_r.bitn == 4'h0 && !s_r.adr_phase)
               s_nxt.sda_oe = !txf_data[7];
            else
               s_nxt.sda_oe = !s_r.sh[8];
            if (s_r.div == 16'h0 && (s_r.bitn != 4'h0 || s_r.adr_phase || s_r.c.read
                || txf_valid)) begin
               s_nxt.scl_oe = 1'b0;
               s_nxt.div = half;
               s_nxt.st = ST_M_BIT_HI;
            end
         end
         ST_M_BIT_HI: if (scl_s && s_r.div == 16'h0) begin
            s_nxt.sh = {s_r.sh[7:0], sda_s};
            s_nxt.scl_oe = 1'b1;
            s_nxt.div = half;
            s_nxt.bitn = s_r.bitn + 4'h1;
            s_nxt.st = ST_M_BIT_LO;
            if (s_r.bitn == 4'h8) begin
               s_nxt.bitn = 4'h0;
               if (!s_r.adr_phase) s_nxt.bcnt = s_r.bcnt + 8'h1;
               if (s_r.c.read && !s_r.adr_phase) begin
                  s_nxt.rxd = {s_r.sh[7:0], sda_s};
                  s_nxt.rxv = rxf_ready;
               end
               if (s_r.adr_phase && s_r.c.ten_bit && !s_r.hdr2 && !sda_s) begin
                  s_nxt.hdr2 = 1'b1;
                  s_nxt.sh = {hdr_byte(s_r.c, 1'b1), 1'b1};
               end else s_nxt.adr_phase = 1'b0;
               if (sda_s && !s_r.c.read) s_nxt.ifg[`IBF_FLAG_STOP] = 1'b1;
               m = (auto_stop_en && byte_count_limit != 8'h0 &&
                    s_r.bcnt + 8'h1 == byte_count_limit && !s_r.adr_phase);
               if (m) s_nxt.ifg[`IBF_FLAG_RX] = 1'b1;
               if (m || (sda_s && !s_r.c.read) || (s_r.c.stop && m)) begin
                  s_nxt.sda_oe = 1'b1;
                  s_nxt.st = ST_M_STOP_LO;
               end else if (!s_r.adr_phase && cmd_valid && cmd.start) begin
                  s_nxt.hdr_sent = 1'b1;
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         ST_M_STOP_LO: if (s_r.div == 16'h0) begin
            s_nxt.scl_oe = 1'b0;
            s_nxt.div = half;
            s_nxt.st = ST_M_STOP_HI;
         end
         ST_M_STOP_HI: if (scl_s && s_r.div == 16'h0) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.hdr_sent = 1'b0;
            s_nxt.st = ST_IDLE;
         end
         ST_S_BIT: begin
            if (scl_rise) begin
               s_nxt.sh = {s_r.sh[7:0], sda_s};
               s_nxt.bitn = s_r.bitn + 4'h1;
            end
            if (scl_fall && s_r.bitn == 4'h8) begin
               b = s_r.sh[7:0];
               s_nxt.ack_me = 1'b0;
               if (s_r.adr_phase) begin
                  for (int i = 0; i < NADDR; i++) begin
                     if (own_addr_en[i] && (own_addr_ten ?
                         (s_r.hdr2 ? b == own_addr[i][7:0] :
                          b[7:1] == {`IBF_HDR10_PAT, own_addr[i][9:8]}) :
                         b[7:1] == own_addr[i][6:0])) begin
                        s_nxt.ack_me = 1'b1;
                        if (!own_addr_ten || s_r.hdr2) s_nxt.amatch[i] = 1'b1;
                     end
                  end
                  if (!s_r.hdr2) s_nxt.sread = b[0];
               end else begin
                  s_nxt.ack_me = rxf_ready;
                  s_nxt.rxd = {b, 1'b0};
                  s_nxt.rxv = rxf_ready;
                  s_nxt.bcnt = s_r.bcnt + 8'h1;
               end
               s_nxt.sda_oe = s_nxt.ack_me;
               s_nxt.st = ST_S_ACK;
            end
         end
         ST_S_ACK: if (scl_fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.bitn = 4'h0;
            if (!s_r.ack_me) s_nxt.st = ST_IDLE;
            else begin
               if (s_r.adr_phase && (!own_addr_ten || s_r.hdr2)) begin
                  s_nxt.ifg[`IBF_FLAG_START] = 1'b1;
                  s_nxt.adr_phase = 1'b0;
               end else if (s_r.adr_phase) s_nxt.hdr2 = 1'b1;
               s_nxt.st = ST_S_BIT;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
      if (s_r.st inside {ST_S_BIT, ST_S_ACK}) begin
         if (stop_det) begin
            s_nxt.st = ST_IDLE;
            s_nxt.sda_oe = 1'b0;
            s_nxt.ifg[`IBF_FLAG_STOP] = 1'b1;
         end else if (start_det) begin
            s_nxt.bitn = 4'h0;
            s_nxt.adr_phase = 1'b1;
            s_nxt.hdr2 = 1'b0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = ST_S_BIT;
         end
      end
      // hardware set beats software clear
      for (int i = 0; i < NADDR; i++) begin
         if (s_nxt.amatch[i]) s_nxt.ifg[`IBF_FLAG_START] = 1'b1;
      end
      if (s_nxt.rxv) s_nxt.ifg[`IBF_FLAG_RX] = 1'b1;
      if (txf_valid == 1'b0) s_nxt.ifg[`IBF_FLAG_TX] = 1'b1;
      if (s_r.hold || !is_i2c) begin
         s_nxt.st = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
         s_nxt.scl_oe = 1'b0;
         s_nxt.rxv = 1'b0;
         s_nxt.amatch = '0;
         s_nxt.hdr_sent = 1'b0;
      end
      if (s_nxt.hold) begin
         s_nxt.stat = s_nxt.stat & `IBF_STAT_RST_MASK;
         s_nxt.ien = 8'h0;
         s_nxt.ifg = 8'h0;
         s_nxt.bcnt = 8'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.sda_sy <= 3'h7;
         s_r.scl_sy <= 3'h7;
         s_r.sda_q <= 1'b1;
         s_r.scl_q <= 1'b1;
         s_r.hold <= 1'b1;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         soft_reset_hold <= 1'b1;
         status_word_reg <= 16'h0;
         int_enable_reg <= 8'h0;
         int_flag_reg <= 8'h0;
         addr_match_evt <= '0;
         bus_busy_flag <= 1'b0;
         start_match_flag <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         soft_reset_hold <= s_nxt.hold;
         status_word_reg <= s_nxt.stat;
         int_enable_reg <= s_nxt.ien;
         int_flag_reg <= s_nxt.ifg;
         addr_match_evt <= s_nxt.amatch;
         bus_busy_flag <= s_nxt.stat[`IBF_STAT_BUSY];
         start_match_flag <= s_nxt.ifg[`IBF_FLAG_START];
         sda_oe <= s_nxt.sda_oe;
         scl_oe <= s_nxt.scl_oe;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_hold_quiet: assert property (@(posedge clk) disable iff (!resetn)
      s_r.hold |=> !sda_oe && !scl_oe) else $error("drivers active in hold");
   a_hold_clears: assert property (@(posedge clk) disable iff (!resetn)
      s_r.hold |-> int_flag_reg == 8'h0 && int_enable_reg == 8'h0)
      else $error("flags not cleared in hold");
   a_busy_start: assert property (@(posedge clk) disable iff (!resetn)
      start_det && !s_r.hold |=> bus_busy_flag) else $error("busy not set");
   a_busy_stop: assert property (@(posedge clk) disable iff (!resetn)
      stop_det && !start_det |=> !bus_busy_flag) else $error("busy not cleared");
   a_stat_mask: assert property (@(posedge clk) disable iff (!resetn)
      s_r.hold |-> status_word_reg[15:8] == 8'h0 && status_word_reg[6:4] == 3'h0)
      else $error("status not cleared");
   a_sda_stable: assert property (@(posedge clk) disable iff (!resetn)
      s_r.st == ST_M_BIT_HI && $past(s_r.st) == ST_M_BIT_HI |-> $stable(sda_oe))
      else $error("sda moved with scl high");
   a_rst_hold: assert property (@(posedge clk)
      $rose(resetn) |-> soft_reset_hold) else $error("hold not set after reset");
   a_release: assert property (@(posedge clk) disable iff (!resetn)
      soft_reset_clr && !soft_reset_set |=> !soft_reset_hold)
      else $error("hold not released");
endmodule
`default_nettype wire

// File: core/ibf_pkg.sv
// types for the i2c framing block
package ibf_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_M_START, ST_M_BIT_LO, ST_M_BIT_HI, ST_M_STOP_LO, ST_M_STOP_HI,
      ST_S_BIT, ST_S_ACK
   } ibf_state_e;
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       read;
      logic       ten_bit;
      logic [9:0] addr;
   } ibf_cmd_s;
   typedef struct packed {
      logic [7:0] data;
      logic       ack;
   } ibf_byte_s;
endpackage

// File: verif/ibf_i2c_tb.sv
// testbench for the i2c framing core
`timescale 1ns/100ps
`default_nettype none
`include "ibf_defs.svh"
module ibf_i2c_tb;
   import ibf_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic srs, src, sync_b, mst_b, fast, ten, ast, cmd_valid, tx_valid, rx_ready, ie_we;
   logic [1:0] mode;
   logic [15:0] div;
   logic [9:0] own_addr [4];
   logic [3:0] own_en;
   logic [7:0] lim, tx_data, ie_wr, fl_clr;
   ibf_cmd_s cmd;
   logic tx_ready, rx_valid, hold, busy, smf, sda_o, sda_oe, scl_o, scl_oe, m_oe, stb;
   logic [8:0] rx_data;
   logic [15:0] stat;
   logic [7:0] ie_reg, fl_reg, m_byte;
   logic [3:0] am_evt;
   wire sda = !(sda_oe | m_oe);
   wire scl = !scl_oe;
   int num_errors = 0;
   int tests_run = 0;
   int n;
   logic [31:0] rnd = 32'h307763d1;
   logic [7:0] exp_q [$];
   always #12.5 clk = ~clk;
   ibf_i2c i_ibf_i2c (.clk(clk), .resetn(resetn), .soft_reset_set(srs), .soft_reset_clr(src),
      .mode_select_field(mode), .sync_mode_bit(sync_b), .master_select_bit(mst_b),
      .fast_mode(fast), .bit_rate_div(div), .own_addr(own_addr), .own_addr_en(own_en),
      .own_addr_ten(ten), .byte_count_limit(lim), .auto_stop_en(ast), .cmd(cmd),
      .cmd_valid(cmd_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .int_enable_wr(ie_wr),
      .int_enable_we(ie_we), .int_flag_clr(fl_clr), .soft_reset_hold(hold),
      .status_word_reg(stat), .int_enable_reg(ie_reg), .int_flag_reg(fl_reg),
      .addr_match_evt(am_evt), .bus_busy_flag(busy), .start_match_flag(smf),
      .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .scl_i(scl));
   ibf_slave_model i_ibf_slave_model (.sda(sda), .scl(scl), .sda_oe(m_oe), .byte_o(m_byte),
      .byte_stb(stb));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR %0t got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge stb) begin
      tests_run++;
      if (exp_q.size() == 0 || m_byte !== exp_q[0]) begin
         $display("ERROR %0t unexpected byte %h on bus", $time, m_byte);
         num_errors++;
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   end
   initial begin
      #500000;
      num_errors++;
      final_report();
   end
   initial begin
      {srs, src, fast, ten, ast, cmd_valid, tx_valid, rx_ready, ie_we} = '0;
      {sync_b, mst_b} = 2'h3;
      mode = 2'h0;
      div = 16'h0004;
      own_addr = '{10'h012, 10'h034, 10'h056, 10'h078};
      own_en = 4'h0;
      lim = 8'h04;
      tx_data = 8'h00;
      ie_wr = 8'h00;
      fl_clr = 8'h00;
      cmd = '0;
      repeat (3) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      @(negedge clk);
      chk(16'(hold), 16'h0001);
      chk({14'h0, sda_oe, scl_oe}, 16'h0000);
      mode = `IBF_MODE_I2C;
      ast = 1'b1;
      pulse(src);
      chk(16'(hold), 16'h0000);
      ie_wr = 8'h03;
      pulse(ie_we);
      chk(16'(ie_reg), 16'h0003);
      rnd = lfsr(rnd);
      cmd = '{start: 1'b1, stop: 1'b1, read: 1'b0, ten_bit: 1'b0, addr: {3'h0, rnd[6:0]}};
      exp_q.push_back({rnd[6:0], 1'b0});
      for (n = 0; n < 4; n++) begin
         rnd = lfsr(rnd);
         @(negedge clk);
         tx_data = rnd[7:0];
         tx_valid = 1'b1;
         exp_q.push_back(rnd[7:0]);
      end
      @(negedge clk) tx_valid = 1'b0;
      chk(16'(tx_ready), 16'h0000);
      cmd_valid = 1'b1;
      for (n = 0; n < 2000 && busy !== 1'b1; n++) @(negedge clk);
      chk(16'(busy), 16'h0001);
      cmd_valid = 1'b0;
      for (n = 0; n < 5000 && busy !== 1'b0; n++) @(negedge clk);
      chk(16'(busy), 16'h0000);
      chk(16'(exp_q.size()), 16'h0000);
      chk(stat & 16'hff00, {lim, 8'h00});
      chk({12'h0, am_evt}, 16'h0000);
      chk({13'h0, smf, sda_o, scl_o}, 16'h0000);
      chk(16'(fl_reg[`IBF_FLAG_TX]), 16'h0001);
      pulse(srs);
      chk(16'(hold), 16'h0001);
      chk(stat & 16'hff70, 16'h0000);
      chk({ie_reg, fl_reg}, 16'h0000);
      chk({14'h0, sda_oe, scl_oe}, 16'h0000);
      pulse(src);
      chk(16'(hold), 16'h0000);
      @(negedge clk) resetn = 1'b0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk(16'(hold), 16'h0001);
      final_report();
   end
endmodule
`default_nettype wire

// File: verif/ibf_slave_model.sv
// behavioural i2c slave on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module ibf_slave_model (
   input  wire logic       sda,
   input  wire logic       scl,
   output logic            sda_oe,
   output logic [7:0]      byte_o,
   output logic            byte_stb
);
   logic       frame;
   logic [7:0] sh;
   int         i;
   initial begin
      sda_oe   = 1'b0;
      byte_stb = 1'b0;
      byte_o   = 8'h00;
   end
   always begin
      @(negedge sda iff scl === 1'b1);
      frame = 1'b1;
      while (frame) begin
         for (i = 0; i < 8 && frame; i++) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
            @(negedge scl or sda);
            if (scl === 1'b1) frame = 1'b0;
         end
         if (frame) begin
            byte_o   = sh;
            byte_stb = 1'b1;
            #1 byte_stb = 1'b0;
            sda_oe = 1'b1;
            @(posedge scl);
            @(negedge scl);
            sda_oe = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
